// ### common/flash_host_pkg.sv
// constants for the flash command host controller
// assumes an 8-bit asynchronous flash behind chip select, output and write enables
package flash_host_pkg;
  // command codes written to the device
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // identifier addresses
  localparam logic [19:0] ID_MAKER_ADDR = 20'h00000;
  localparam logic [19:0] ID_PART_ADDR = 20'h00001;
  localparam logic [15:0] ID_BLOCK_LOCK_OFS = 16'h0002;
  localparam logic [19:0] ID_MASTER_LOCK_ADDR = 20'h00003;
  // status byte field positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_LOCK_VIOL = 1;
  localparam int LOCK_BIT = 0;
  // host register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // operation codes in the control register
  localparam logic [3:0] OP_READ_ARRAY = 4'h0;
  localparam logic [3:0] OP_READ_ID = 4'h1;
  localparam logic [3:0] OP_READ_STATUS = 4'h2;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
  localparam logic [3:0] OP_ERASE = 4'h4;
  localparam logic [3:0] OP_WRITE = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME = 4'h7;
  localparam logic [3:0] OP_READ = 4'h8;
  // bus phase timing in ns and derived cycles
  localparam int CLK_NS = 20;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
endpackage

// ### core/flash_pin_sync.sv
// two-flop synchroniser for flash pins
// assumes inputs are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module flash_pin_sync #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // per-bit double flop
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ### core/flash_command_host.sv
// host controller writing command sequences into an 8-bit flash
// assumes software drives a plain strobe register port; flash pins are asynchronous
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module flash_command_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // software register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [7:0] flash_data_i,
  output logic [7:0] flash_data_o,
  output logic flash_data_oe_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  input wire logic ready_busy_output_i
);
  import flash_host_pkg::*;

  typedef enum {ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_GAP, ST_RD_LOW, ST_RD_HIGH} bus_state_e;
  typedef enum {MODE_ARRAY, MODE_ID, MODE_STATUS} read_mode_e;

  bus_state_e state_reg, state_next;
  read_mode_e mode_reg;
  logic [3:0] cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [3:0] op_reg;
  logic second_reg;
  logic suspended_reg;
  logic refused_reg;
  logic [7:0] status_shadow_reg;
  logic [31:0] rdout_reg;
  logic [8:0] pins_sync;
  logic [7:0] data_sync;
  logic ready_sync;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  flash_pin_sync #(.WIDTH(9)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({~ready_busy_output_i, flash_data_i}),
    .sync_o(pins_sync)
  );
  assign data_sync = pins_sync[7:0];
  // ready pin travels inverted so the flop reset value reads as ready
  assign ready_sync = ~pins_sync[8];

  ////////////////////////////////////////////////////////////////////////////
  // command decode of a software start
  wire busy = (state_reg != ST_IDLE);
  wire start = reg_write_i && (reg_addr_i == REG_CTRL) && !busy;
  wire [3:0] op_in = reg_wdata_i[3:0];
  wire alt_setup = reg_wdata_i[4];
  wire machine_busy = !ready_sync && !suspended_reg;
  // array read refused while running, allowed when suspended
  wire refuse_array = (op_in == OP_READ_ARRAY) && machine_busy;
  // clear status, erase and identifier are refused while an erase is suspended
  wire refuse_susp = suspended_reg && ((op_in == OP_CLEAR_STATUS) || (op_in == OP_ERASE)
                     || (op_in == OP_READ_ID));
  wire refuse = refuse_array || refuse_susp;
  wire go = start && !refuse;
  wire two_cycle = (op_reg == OP_ERASE) || (op_reg == OP_WRITE);
  wire [7:0] write_setup = alt_setup ? CMD_WRITE_SETUP_ALT : CMD_WRITE_SETUP;
  wire [7:0] first_byte =
    (op_in == OP_READ_ARRAY) ? CMD_READ_ARRAY :
    (op_in == OP_READ_ID) ? CMD_READ_ID :
    (op_in == OP_READ_STATUS) ? CMD_READ_STATUS :
    (op_in == OP_CLEAR_STATUS) ? CMD_CLEAR_STATUS :
    (op_in == OP_ERASE) ? CMD_ERASE_SETUP :
    (op_in == OP_WRITE) ? write_setup :
    (op_in == OP_SUSPEND) ? CMD_SUSPEND :
    CMD_CONFIRM;
  wire is_read = (op_in == OP_READ);
  wire cnt_done = (cnt_reg == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go && is_read) begin
          state_next = ST_RD_LOW;
        end else if (go) begin
          state_next = ST_WR_LOW;
        end
      end
      ST_WR_LOW: begin
        if (cnt_done) begin
          state_next = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (cnt_done && two_cycle && !second_reg) begin
          state_next = ST_GAP;
        end else if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_GAP: begin
        state_next = ST_WR_LOW;
      end
      ST_RD_LOW: begin
        if (cnt_done) begin
          state_next = ST_RD_HIGH;
        end
      end
      ST_RD_HIGH: begin
        // strobe back high before the next read refreshes status
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state and phase counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? STROBE_CNT : (cnt_done ? 4'h0 : cnt_reg - 4'h1);
    end
  end

  // captured request
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_reg <= OP_READ_ARRAY;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      second_reg <= 1'b0;
    end else if (go) begin
      op_reg <= op_in;
      wdata_reg <= first_byte;
      second_reg <= 1'b0;
    end else if (state_reg == ST_GAP) begin
      // second cycle: confirm for erase, data for byte write, same address
      wdata_reg <= (op_reg == OP_ERASE) ? CMD_CONFIRM : status_shadow_reg;
      second_reg <= 1'b1;
    end else if (reg_write_i && reg_addr_i == REG_ADDR && !busy) begin
      addr_reg <= reg_wdata_i[ADDR_W-1:0];
    end
  end

  // software data byte kept for the write second cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_shadow_reg <= ERASED_BYTE;
    end else if (reg_write_i && reg_addr_i == REG_WDATA && !busy) begin
      status_shadow_reg <= reg_wdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tracked device read mode and suspend state
  wire cmd_done = (state_reg == ST_WR_HIGH) && cnt_done && (!two_cycle || second_reg);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= MODE_ARRAY;
      suspended_reg <= 1'b0;
    end else if (go && (op_in == OP_SUSPEND)) begin
      // judged at the request: the ready pin rises as soon as the device suspends
      suspended_reg <= suspended_reg || machine_busy;
    end else if (cmd_done) begin
      case (op_reg)
        OP_READ_ARRAY: mode_reg <= MODE_ARRAY;
        OP_READ_ID: mode_reg <= MODE_ID;
        OP_CLEAR_STATUS: mode_reg <= mode_reg;
        OP_SUSPEND: mode_reg <= MODE_STATUS;
        OP_RESUME: begin
          mode_reg <= MODE_STATUS;
          suspended_reg <= 1'b0;
        end
        default: mode_reg <= MODE_STATUS;
      endcase
    end
  end

  // read data sampled at end of low strobe; refused flag sticky until a start
  wire sample = (state_reg == ST_RD_LOW) && cnt_done;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      if (sample) begin
        rdata_reg <= data_sync;
      end
      if (start) begin
        refused_reg <= refuse;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  wire wr_phase = (state_reg == ST_WR_LOW);
  wire rd_phase = (state_reg == ST_RD_LOW);
  assign flash_addr_o = addr_reg;
  assign flash_data_o = wdata_reg;
  assign flash_data_oe_o = wr_phase || (state_reg == ST_WR_HIGH);
  assign flash_ce_n_o = !(wr_phase || rd_phase);
  assign flash_oe_n_o = !rd_phase;
  assign flash_we_n_o = !wr_phase; // data latched by device on we rise

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, data one cycle later
  wire [7:0] status_word = {2'b00, mode_reg == MODE_STATUS, mode_reg == MODE_ID,
                            suspended_reg, refused_reg, ready_sync, busy};
  wire [31:0] rd_sel =
    (reg_addr_i == REG_CTRL) ? {28'h0000000, op_reg} :
    (reg_addr_i == REG_ADDR) ? {{(32-ADDR_W){1'b0}}, addr_reg} :
    (reg_addr_i == REG_WDATA) ? {24'h000000, status_shadow_reg} :
    (reg_addr_i == REG_RDATA) ? {24'h000000, rdata_reg} :
    (reg_addr_i == REG_STATUS) ? {24'h000000, status_word} :
    32'h00000000;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdout_reg <= 32'h00000000;
    end else begin
      rdout_reg <= reg_read_i ? rd_sel : 32'h00000000;
    end
  end
  assign reg_rdata_o = rdout_reg;
endmodule
`default_nettype wire

// ### tb/flash_dev_model.sv
// behavioural flash device facing the host controller
// assumes host strobes arrive active low; block 1 is locked
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h3c, // arbitrary value
  parameter logic [7:0] PART = 8'hc3, // arbitrary value
  parameter int ERASE_T = 300
) (
  // host strobes and buses
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic ready_busy_output_o,
  // supply and override levels
  input wire logic supply_low_i,
  input wire logic override_i
);
  logic [7:0] mem [16];
  logic [7:0] sr = '0, q = '0;
  logic [1:0] mode = '0, pend = '0; // array, id, status
  logic susp = 1'b0;
  int left = 0, saved = 0;
  wire locked = addr_i[19:16] == 4'h1;
  wire wr_act = !ce_n_i && !we_n_i;
  wire rd_act = !ce_n_i && !oe_n_i;
  wire [7:0] srd = {left == 0, susp, sr[5:0]};
  initial for (int i = 0; i < 16; i++) mem[i] = 8'h5a ^ 8'(i);
  // machine run time and ready pin
  always #20 if (left > 0) left--;
  assign ready_busy_output_o = left == 0;
  // command decode when the first of write strobe and chip select rises
  always @(negedge wr_act) begin
    if (pend == 2'd1) begin
      if (data_i != CMD_CONFIRM) sr |= 8'h30;
      else if (supply_low_i) sr |= 8'h28;
      else if (locked && !override_i) sr |= 8'h22;
      else begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        left = ERASE_T;
      end
      pend = '0;
      mode = 2'd2;
    end else if (pend == 2'd2) begin
      if (supply_low_i) sr |= 8'h18;
      else if (locked && !override_i) sr |= 8'h12;
      else begin
        mem[addr_i[3:0]] &= data_i;
        left = 80;
      end
      pend = '0;
      mode = 2'd2;
    end else case (data_i)
      CMD_READ_ARRAY: if (left == 0 || susp) mode = '0;
      CMD_READ_ID: if (!susp) mode = 2'd1;
      CMD_READ_STATUS: mode = 2'd2;
      CMD_CLEAR_STATUS: if (!susp) sr = '0;
      CMD_ERASE_SETUP: if (!susp) pend = 2'd1;
      CMD_WRITE_SETUP, CMD_WRITE_SETUP_ALT: pend = 2'd2;
      CMD_SUSPEND: if (left > 0 && !susp) begin
        susp = 1'b1;
        saved = left;
        left = 0;
        mode = 2'd2;
      end
      CMD_CONFIRM: if (susp) begin
        susp = 1'b0;
        left += saved;
        mode = 2'd2;
      end
      default: ;
    endcase
  end
  // output latch when read strobe and chip select are both low
  always @(posedge rd_act) begin
    if (mode == 2'd2) q = srd;
    else if (mode == 2'd0) q = mem[addr_i[3:0]];
    else if (addr_i == ID_MAKER_ADDR) q = MAKER;
    else if (addr_i == ID_PART_ADDR) q = PART;
    else q = {7'h0, addr_i[15:0] == ID_BLOCK_LOCK_OFS && locked};
  end
  // released bus shows the inverse of the last byte
  assign data_o = rd_act ? q : ~q;
endmodule
`default_nettype wire

// ### tb/flash_command_host_chk.sv
// pin protocol checks for the flash command host
// assumes binding onto flash_command_host
`timescale 1ns/100ps
`default_nettype none
module flash_command_host_chk #(
  parameter int ADDR_W = 20
) (
  // clock, reset and flash pins
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [7:0] flash_data_o,
  input wire logic flash_data_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_idle: assert property ($rose(reset_n_i) |-> flash_ce_n_o && flash_we_n_o)
    else $error("strobe active after reset");
  a_we_low_len: assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o)[*6] ##1 flash_we_n_o)
    else $error("write strobe low phase length");
  a_oe_high_gap: assert property ($rose(flash_oe_n_o) |-> flash_oe_n_o[*6])
    else $error("output enable not high between reads");
  a_we_drives: assert property (!flash_we_n_o |-> flash_data_oe_o)
    else $error("data not driven during write");
  a_no_fight: assert property (!flash_oe_n_o |-> !flash_data_oe_o)
    else $error("data driven during read");
  a_no_both: assert property (!(!flash_oe_n_o && !flash_we_n_o))
    else $error("read and write strobes together");
  a_ce_with_strobe: assert property ((!flash_oe_n_o || !flash_we_n_o) |-> !flash_ce_n_o)
    else $error("strobe without chip select");
  a_we_hold: assert property (!flash_we_n_o && !$past(flash_we_n_o)
    |-> $stable(flash_data_o) && $stable(flash_addr_o))
    else $error("write data or address moved");
  a_rd_addr_hold: assert property (!flash_oe_n_o && !$past(flash_oe_n_o)
    |-> $stable(flash_addr_o))
    else $error("read address moved");
  c_write: cover property ($fell(flash_we_n_o));
  c_read: cover property ($fell(flash_oe_n_o));
  c_back: cover property ($rose(flash_we_n_o) ##[1:8] $fell(flash_we_n_o));
endmodule
bind flash_command_host flash_command_host_chk #(.ADDR_W(ADDR_W)) flash_command_host_chk_i (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .flash_addr_o(flash_addr_o),
  .flash_data_o(flash_data_o), .flash_data_oe_o(flash_data_oe_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));
`default_nettype wire

// ### tb/tb_flash_command_host.sv
// self-checking bench for the flash command host
// assumes the device model answers on the flash pins
`timescale 1ns/100ps
`default_nettype none
module tb_flash_command_host;
  import flash_host_pkg::*;
  logic clk_i = 0, reset_n_i = 0, reg_write_i = 0, reg_read_i = 0, low = 0, ovr = 0;
  logic [3:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, v;
  wire [31:0] reg_rdata_o;
  wire [19:0] fa;
  wire [7:0] fdo, dev_q, fdi;
  wire foe, ce, oe, we, rb;
  int bad_count = 0, checks_done = 0;
  localparam logic [7:0] DEV_MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] DEV_PART = 8'hc3; // arbitrary value
  assign fdi = foe ? fdo : dev_q;
  flash_command_host flash_command_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .flash_addr_o(fa), .flash_data_i(fdi),
    .flash_data_o(fdo), .flash_data_oe_o(foe), .flash_ce_n_o(ce), .flash_oe_n_o(oe),
    .flash_we_n_o(we), .ready_busy_output_i(rb));
  flash_dev_model #(.MAKER(DEV_MAKER), .PART(DEV_PART)) flash_dev_model_i (.ce_n_i(ce),
    .oe_n_i(oe), .we_n_i(we), .addr_i(fa),
    .data_i(fdi), .data_o(dev_q), .ready_busy_output_o(rb), .supply_low_i(low),
    .override_i(ovr));
  initial forever #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1 v = reg_rdata_o;
    @(posedge clk_i);
  endtask
  // one host operation, then wait for the host to go idle
  task automatic op(input logic [4:0] c, input logic [19:0] a, input logic [7:0] d);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    wr(REG_CTRL, 32'(c));
    repeat (200) begin
      rd(REG_STATUS);
      if (v[0] === 1'b0) break;
    end
    chk(32'(v[0]), 32'h0);
  endtask
  task automatic rdb(input logic [19:0] a, input logic [7:0] e);
    op(5'(OP_READ), a, 8'h00);
    rd(REG_RDATA);
    chk(v, 32'(e));
  endtask
  task automatic wait_dev();
    repeat (2000) begin
      rd(REG_STATUS);
      if (v[1] === 1'b1) break;
    end
    chk(32'(v[1]), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ident();
    rdb(20'h3, 8'h59);
    op(5'(OP_READ_ID), 20'h0, 8'h0);
    rd(REG_STATUS);
    chk(32'(v[4]), 32'h1);
    rdb(ID_MAKER_ADDR, DEV_MAKER);
    rdb(ID_PART_ADDR, DEV_PART);
    rdb(20'h10002, 8'h01);
    rdb(ID_MASTER_LOCK_ADDR, 8'h00);
    op(5'(OP_READ_ARRAY), 20'h0, 8'h0);
    rdb(20'h3, 8'h59);
  endtask
  task automatic t_write();
    op(5'(OP_WRITE), 20'h5, 8'h0f);
    wait_dev();
    rdb(20'h5, 8'h80);
    rd(REG_STATUS);
    chk(32'(v[5]), 32'h1);
    op(5'(OP_WRITE) | 5'h10, 20'h6, 8'hf0);
    wait_dev();
    op(5'(OP_READ_ARRAY), 20'h0, 8'h0);
    rdb(20'h5, 8'h0f);
    rdb(20'h6, 8'h50);
    op(5'(OP_READ_STATUS), 20'h0, 8'h0);
    rdb(20'h0, 8'h80);
  endtask
  task automatic t_erase();
    op(5'(OP_ERASE), 20'h0, 8'h0);
    rdb(20'h0, 8'h00);
    op(5'(OP_READ_ARRAY), 20'h0, 8'h0);
    rd(REG_STATUS);
    chk(32'(v[2]), 32'h1);
    wait_dev();
    op(5'(OP_READ_ARRAY), 20'h0, 8'h0);
    rdb(20'h2, ERASED_BYTE);
  endtask
  task automatic t_errors();
    op(5'(OP_ERASE), 20'h10000, 8'h0);
    rdb(20'h0, 8'ha2);
    low <= 1'b1;
    op(5'(OP_WRITE), 20'h1, 8'h00);
    rdb(20'h0, 8'hba);
    low <= 1'b0;
    op(5'(OP_CLEAR_STATUS), 20'h0, 8'h0);
    rdb(20'h0, 8'h80);
    low <= 1'b1;
    op(5'(OP_ERASE), 20'h0, 8'h0);
    rdb(20'h0, 8'ha8);
    low <= 1'b0;
    op(5'(OP_CLEAR_STATUS), 20'h0, 8'h0);
    op(5'(OP_WRITE), 20'h10001, 8'h00);
    rdb(20'h0, 8'h92);
    ovr <= 1'b1;
    op(5'(OP_CLEAR_STATUS), 20'h0, 8'h0);
    op(5'(OP_WRITE), 20'h10004, 8'h00);
    wait_dev();
    rdb(20'h0, 8'h80);
    ovr <= 1'b0;
  endtask
  task automatic t_suspend();
    op(5'(OP_ERASE), 20'h0, 8'h0);
    op(5'(OP_SUSPEND), 20'h0, 8'h0);
    rdb(20'h0, 8'hc0);
    rd(REG_STATUS);
    chk(32'(v[3]), 32'h1);
    op(5'(OP_CLEAR_STATUS), 20'h0, 8'h0);
    rd(REG_STATUS);
    chk(32'(v[2]), 32'h1);
    op(5'(OP_WRITE), 20'h7, 8'h00);
    rdb(20'h0, 8'h40);
    wait_dev();
    op(5'(OP_RESUME), 20'h0, 8'h0);
    rdb(20'h0, 8'h00);
    wait_dev();
    rdb(20'h0, 8'h80);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(REG_RDATA);
    chk(v, 32'h0);
    rd(4'hf);
    chk(v, 32'h0);
    t_ident();
    t_write();
    t_erase();
    t_errors();
    t_suspend();
    give_verdict();
  end
  // watchdog
  initial begin
    #1500000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
